// ==== swdt_top.sv ====
// System watchdog timer: 21-bit timer with an 8-bit control port.
// Assumes the wr_en_in strobe comes from logic on clk_in; system reset is
// fed back to rst_b_in by the surrounding reset logic.
`timescale 1ns/1ps
`default_nettype none
module swdt_top
    import swdt_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_data_in,
    output logic      [7:0] rd_data_out,
    output logic            wdt_reset_req_out,
    output logic            reset_flag_out
);
    import swdt_pkg::*;

    logic                enable_q;
    logic                lock_q;
    logic [2:0]          ivl_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [CNT_W-1:0]    limit;
    swdt_dis_t           dis_q;
    logic [2:0]          dis_cnt_q;
    logic                overflow;
    logic                reload_wr;
    logic                disable_ok;
    logic                flag_q;
    logic                req_q;

    // Limit is 4^(3+n) - 1; n = 7 gives 2^20 - 1, inside 21 bits
    always_comb begin
        limit = CNT_RESET;
        limit = (CNT_ONE << (6 + 2 * ivl_q)) - CNT_ONE;
    end

    assign reload_wr  = wr_en_in && (wr_data_in == CODE_RELOAD);
    // At-or-above, so shrinking the interval cannot skip the limit
    assign overflow   = enable_q && (cnt_q >= limit);
    assign disable_ok = wr_en_in && (wr_data_in == CODE_DIS_2) &&
                        (dis_q == SWDT_ARMED) && !lock_q;

    // Counter
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_q <= CNT_RESET;
        end else if (reload_wr || overflow) begin
            cnt_q <= CNT_RESET;
        end else if (enable_q) begin
            cnt_q <= cnt_q + CNT_ONE;
        end
    end

    // Enable state; ff write leaves it alone
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            enable_q <= ENABLE_RESET;
        end else if (reload_wr) begin
            enable_q <= 1'b1;
        end else if (disable_ok) begin
            enable_q <= 1'b0;
        end
    end

    // Lockout: only a system reset clears it
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            lock_q <= LOCK_RESET;
        end else if (wr_en_in && wr_data_in == CODE_LOCK) begin
            lock_q <= 1'b1;
        end
    end

    // Interval field, only with bit 7 clear
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ivl_q <= IVL_RESET;
        end else if (wr_en_in && !wr_data_in[IVL_GATE_BIT]) begin
            ivl_q <= wr_data_in[IVL_MSB:0];
        end
    end

    // Disable sequencer; window counts cycles since the de write
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            dis_q     <= SWDT_IDLE;
            dis_cnt_q <= 3'h0;
        end else begin
            case (dis_q)
                SWDT_IDLE: begin
                    if (wr_en_in && wr_data_in == CODE_DIS_1) begin
                        dis_q     <= SWDT_ARMED;
                        dis_cnt_q <= DIS_CNT_W1;
                    end
                end
                SWDT_ARMED: begin
                    if (wr_en_in && wr_data_in == CODE_DIS_1) begin
                        dis_cnt_q <= DIS_CNT_W1;
                    end else if (wr_en_in) begin
                        dis_q <= SWDT_IDLE;
                    end else if (dis_cnt_q == 3'(DIS_WINDOW)) begin
                        dis_q <= SWDT_IDLE;
                    end else begin
                        dis_cnt_q <= dis_cnt_q + 3'h1;
                    end
                end
                default: begin
                    dis_q <= SWDT_IDLE;
                end
            endcase
        end
    end

    // Reset request is registered from overflow and driven out on wdt_reset_req_out
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            req_q <= 1'b0;
        end else begin
            req_q <= overflow;
        end
    end
    assign wdt_reset_req_out = req_q;

    // Flag survives the reset it caused: sampled at reset
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            flag_q <= req_q;
        end
    end
    assign reset_flag_out = flag_q;

    always_comb begin
        rd_data_out                 = 8'h00;
        rd_data_out[IVL_MSB:0]      = ivl_q;
        rd_data_out[ACTIVE_BIT]     = enable_q;
    end

    // No disable here: the request itself pulls the reset low
    property p_overflow_req;
        @(posedge clk_in)
        rst_b_in && overflow |=> wdt_reset_req_out;
    endproperty
    a_overflow_req: assert property (p_overflow_req)
        else $error("overflow did not request reset");

    property p_reload;
        @(posedge clk_in) disable iff (!rst_b_in)
        reload_wr |=> (cnt_q == CNT_RESET) && enable_q;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload did not clear and enable");

    property p_lock_holds;
        @(posedge clk_in) disable iff (!rst_b_in)
        lock_q && enable_q |=> enable_q;
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("watchdog disabled while locked");

    property p_disable;
        @(posedge clk_in) disable iff (!rst_b_in)
        (!lock_q && wr_en_in && wr_data_in == CODE_DIS_1 && !reload_wr)
        ##1 (wr_en_in && wr_data_in == CODE_DIS_2) |=> !enable_q;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable pair ignored");

    property p_late_disable;
        @(posedge clk_in) disable iff (!rst_b_in)
        (enable_q && wr_en_in && wr_data_in == CODE_DIS_1)
        ##1 !wr_en_in [*4] |=> (dis_q == SWDT_IDLE);
    endproperty
    a_late_disable: assert property (p_late_disable)
        else $error("disable window stayed open too long");

    property p_ff_no_reload;
        @(posedge clk_in) disable iff (!rst_b_in)
        (wr_en_in && wr_data_in == CODE_LOCK && enable_q && !overflow)
        |=> cnt_q == $past(cnt_q) + CNT_ONE;
    endproperty
    a_ff_no_reload: assert property (p_ff_no_reload)
        else $error("ff write touched the counter");

    property p_status;
        @(posedge clk_in) disable iff (!rst_b_in)
        rd_data_out[ACTIVE_BIT] == enable_q && rd_data_out[7:5] == 3'h0;
    endproperty
    a_status: assert property (p_status)
        else $error("status bit mismatch");

    property p_count;
        @(posedge clk_in) disable iff (!rst_b_in)
        enable_q && !wr_en_in && !overflow |=> cnt_q != CNT_RESET;
    endproperty
    a_count: assert property (p_count)
        else $error("counter did not advance");

    property p_after_reset;
        @(posedge clk_in)
        !rst_b_in |=> enable_q && ivl_q == IVL_RESET && !lock_q;
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("bad state after reset");

    property p_req_pulse;
        @(posedge clk_in)
        wdt_reset_req_out |=> !wdt_reset_req_out;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("reset request longer than one cycle");

    property p_req_cause;
        @(posedge clk_in)
        !overflow |=> !wdt_reset_req_out;
    endproperty
    a_req_cause: assert property (p_req_cause)
        else $error("reset request without overflow");

    property p_flag_set;
        @(posedge clk_in)
        !rst_b_in && wdt_reset_req_out |=> reset_flag_out;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("watchdog reset did not set flag");

    property p_flag_clear;
        @(posedge clk_in)
        !rst_b_in && !wdt_reset_req_out |=> !reset_flag_out;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("other reset left flag set");

    property p_lock_set;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_en_in && wr_data_in == CODE_LOCK |=> lock_q;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("ff write did not set lockout");

    property p_lock_sticky;
        @(posedge clk_in) disable iff (!rst_b_in)
        lock_q |=> lock_q;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lockout cleared without reset");

    property p_ff_no_enable;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_en_in && wr_data_in == CODE_LOCK && !enable_q |=> !enable_q;
    endproperty
    a_ff_no_enable: assert property (p_ff_no_enable)
        else $error("ff write enabled the watchdog");

    property p_ivl_write;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_en_in && !wr_data_in[IVL_GATE_BIT]
        |=> ivl_q == $past(wr_data_in[IVL_MSB:0]);
    endproperty
    a_ivl_write: assert property (p_ivl_write)
        else $error("interval write not taken");

    property p_ivl_refused;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_en_in && wr_data_in[IVL_GATE_BIT] |=> $stable(ivl_q);
    endproperty
    a_ivl_refused: assert property (p_ivl_refused)
        else $error("interval changed by a bit 7 write");

    property p_hold_disabled;
        @(posedge clk_in) disable iff (!rst_b_in)
        !enable_q && !reload_wr |=> !enable_q && $stable(cnt_q);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("disabled watchdog moved");

    property p_window_open;
        @(posedge clk_in) disable iff (!rst_b_in)
        (!lock_q && wr_en_in && wr_data_in == CODE_DIS_1)
        ##1 !wr_en_in [*3] ##1 (wr_en_in && wr_data_in == CODE_DIS_2)
        |=> !enable_q;
    endproperty
    a_window_open: assert property (p_window_open)
        else $error("disable refused inside window");

    property p_cancel;
        @(posedge clk_in) disable iff (!rst_b_in)
        dis_q == SWDT_ARMED && wr_en_in && wr_data_in != CODE_DIS_1
        |=> dis_q == SWDT_IDLE;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("other write left disable armed");

    property p_stray_ad;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_en_in && wr_data_in == CODE_DIS_2 && dis_q == SWDT_IDLE &&
        enable_q |=> enable_q;
    endproperty
    a_stray_ad: assert property (p_stray_ad)
        else $error("lone ad write disabled watchdog");
endmodule : swdt_top
`default_nettype wire

// ==== swdt_pkg.sv ====
// Package for the system watchdog timer: field layout, codes, counts.
// Assumes a single system clock domain; no bus beyond the control port.
package swdt_pkg;
    localparam int          CNT_W         = 21;
    localparam logic [7:0]  CODE_RELOAD   = 8'ha5;
    localparam logic [7:0]  CODE_DIS_1    = 8'hde;
    localparam logic [7:0]  CODE_DIS_2    = 8'had;
    localparam logic [7:0]  CODE_LOCK     = 8'hff;
    localparam int          DIS_WINDOW    = 4;
    localparam int          IVL_MSB       = 2;
    localparam int          ACTIVE_BIT    = 4;
    localparam int          IVL_GATE_BIT  = 7;
    localparam logic [2:0]  IVL_RESET     = 3'h7;
    localparam logic [2:0]  DIS_CNT_W1    = 3'h1;
    localparam logic        ENABLE_RESET  = 1'b1;
    localparam logic        LOCK_RESET    = 1'b0;
    localparam logic [CNT_W-1:0] CNT_RESET = 21'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 21'h000001;

    typedef enum logic [0:0] {
        SWDT_IDLE  = 1'b0,
        SWDT_ARMED = 1'b1
    } swdt_dis_t;
endpackage : swdt_pkg

// ==== swdt_tb.sv ====
// Testbench for the system watchdog timer: control writes and timeouts.
// Assumes the reset request is fed back into the synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import swdt_pkg::*;
    logic       clk_in      = 1'b0;
    logic       tb_rst_b    = 1'b0;
    logic       wr_en_in    = 1'b0;
    logic [7:0] wr_data_in  = 8'h00;
    logic       smp         = 1'b0;
    logic [7:0] rd_data_out;
    logic       wdt_reset_req_out;
    logic       reset_flag_out;
    wire        rst_b_in;
    int         miscompares = 0;
    int         comparisons = 0;
    int         since       = 0;
    int         n;
    logic [8:0] rd_q[$];
    int         to_q[$];
    // Request closes the loop, as the surrounding reset logic would
    assign rst_b_in = tb_rst_b & ~wdt_reset_req_out;
    swdt_top swdt_top_inst (
        .clk_in            (clk_in),
        .rst_b_in          (rst_b_in),
        .wr_en_in          (wr_en_in),
        .wr_data_in        (wr_data_in),
        .rd_data_out       (rd_data_out),
        .wdt_reset_req_out (wdt_reset_req_out),
        .reset_flag_out    (reset_flag_out)
    );
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #2;
    endtask : tick
    task automatic fail(input string m);
        miscompares++;
        $display("CHECK FAILED %0t: %s", $time, m);
    endtask : fail
    task automatic cmp_rd(input logic [8:0] e);
        comparisons++;
        if ({reset_flag_out, rd_data_out} !== e) fail("flag/read value");
    endtask : cmp_rd
    task automatic cmp_to(input int e);
        comparisons++;
        // Request is seen exactly limit + 1 cycles after the last reload
        if (since != e) fail("timeout length");
    endtask : cmp_to
    task automatic wr(input logic [7:0] d);
        wr_en_in = 1'b1;
        wr_data_in = d;
        tick(1);
        wr_en_in = 1'b0;
        tick(1);
    endtask : wr
    task automatic pair(input logic [7:0] a, input logic [7:0] b, input int g);
        wr_en_in = 1'b1;
        wr_data_in = a;
        tick(1);
        if (g > 0) begin
            wr_en_in = 1'b0;
            tick(g);
        end
        wr_en_in = 1'b1;
        wr_data_in = b;
        tick(1);
        wr_en_in = 1'b0;
        tick(1);
    endtask : pair
    task automatic chk(input logic [8:0] e);
        rd_q.push_back(e);
        smp = 1'b1;
        tick(1);
        smp = 1'b0;
        tick(1);
    endtask : chk
    task automatic sys_rst;
        tb_rst_b = 1'b0;
        tick(4);
        tb_rst_b = 1'b1;
    endtask : sys_rst
    task automatic wait_req;
        for (int i = 0; i < 2000 && wdt_reset_req_out !== 1'b1; i++) tick(1);
        tick(2);
    endtask : wait_req
    task automatic tally_and_finish;
        miscompares += to_q.size();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_in) begin
        if (smp) cmp_rd(rd_q.pop_front());
        if (wdt_reset_req_out === 1'b1) begin
            if (to_q.size() == 0) fail("unexpected timeout");
            else cmp_to(to_q.pop_front());
        end
        since <= (!rst_b_in || (wr_en_in && wr_data_in == CODE_RELOAD)) ?
                 0 : since + 1;
    end
    initial begin
        void'($urandom(55));
        sys_rst();
        chk(9'h017);
        pair(CODE_DIS_1, CODE_DIS_2, DIS_WINDOW);
        chk(9'h017);
        wr(CODE_DIS_1);
        wr(CODE_RELOAD);
        wr(CODE_DIS_2);
        chk(9'h017);
        pair(CODE_DIS_1, CODE_DIS_2, $urandom_range(3, 0));
        chk(9'h007);
        tick(100);
        chk(9'h007);
        wr(CODE_RELOAD);
        chk(9'h017);
        wr(CODE_LOCK);
        pair(CODE_DIS_1, CODE_DIS_2, 0);
        chk(9'h017);
        wr(8'h82);
        chk(9'h017);
        sys_rst();
        pair(CODE_DIS_1, CODE_DIS_2, DIS_WINDOW - 1);
        chk(9'h007);
        wr(8'h00);
        chk(9'h000);
        wr(CODE_LOCK);
        chk(9'h000);
        wr(CODE_RELOAD);
        chk(9'h010);
        // Reloads spaced inside the 64-cycle timeout (limit 63) must hold off reset
        repeat (6) begin
            tick(40);
            wr(CODE_RELOAD);
        end
        chk(9'h010);
        to_q.push_back(64);
        tick(20);
        wr(CODE_LOCK);
        wait_req();
        chk(9'h117);
        n = $urandom_range(1, 0);
        wr(8'(n));
        chk(9'h110 | 9'(n));
        to_q.push_back(4 ** (3 + n));
        wr(CODE_RELOAD);
        wait_req();
        chk(9'h117);
        sys_rst();
        chk(9'h017);
        tally_and_finish();
    end
    initial begin
        tick(20000);
        fail("watchdog expired");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
